// [verilog/dpt_consts.svh]
// constants for the parameter telegram host controller
// assumes inclusion by bare name from the design file and the testbench
`ifndef DPT_CONSTS_SVH
`define DPT_CONSTS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DPT_OFF_CTRL    8'h00
`define DPT_OFF_PID     8'h04
`define DPT_OFF_INDEX   8'h08
`define DPT_OFF_VALUE   8'h0c
`define DPT_OFF_PROC    8'h10
`define DPT_OFF_ADDR    8'h14
`define DPT_OFF_DTYPE   8'h18
`define DPT_OFF_STATUS  8'h1c
`define DPT_OFF_RVAL    8'h20
`define DPT_OFF_RPROC   8'h24
`define DPT_OFF_RPID    8'h28
`define DPT_OFF_SCALED  8'h2c
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DPT_CTRL_GO     0
`define DPT_CTRL_BCAST  1
`define DPT_CTRL_NLO    2
`define DPT_CTRL_NHI    4
`define DPT_ST_BUSY     0
`define DPT_ST_DONE     1
`define DPT_ST_TMO      2
`define DPT_ST_FAULT    3
`define DPT_ST_CFGERR   4
`define DPT_CMD_HI      15
`define DPT_CMD_LO      12
`define DPT_PNU_HI      10
// ------------------------------------------------------------
// command, response, data type and conversion codes
// ------------------------------------------------------------
`define DPT_CMD_NONE    4'h0
`define DPT_CMD_RD      4'h1
`define DPT_CMD_WR_W    4'h2
`define DPT_CMD_WR_EE_W 4'he
`define DPT_CMD_TEXT    4'hf
`define DPT_RSP_FAULT   4'h7
`define DPT_IDX_TXT_RD  8'h04
`define DPT_IDX_TXT_WR  8'h05
`define DPT_DT_I16      8'h03
`define DPT_DT_U8       8'h05
`define DPT_DT_U16      8'h06
`define DPT_DT_TEXT     8'h09
`define DPT_CONV_SPEC   8'h4a
`define DPT_CONV_X100   8'h02
`define DPT_CONV_X10    8'h01
// ------------------------------------------------------------
// framing sizes, addresses and timing
// ------------------------------------------------------------
`define DPT_HDR_BYTES   4'h4
`define DPT_VAL_BYTES   3'h4
`define DPT_LEN_FIXED   8'h0a
`define DPT_ADDR_BCAST  8'h00
`define DPT_ADDR_MAX    8'hf7
`define DPT_TMO_US      50000
`define DPT_CLK_MHZ     20
`endif

// [verilog/dpt_pkg.sv]
// types for the parameter telegram host controller
// assumes dpt_consts.svh supplies all numeric constants
package dpt_pkg;
   typedef enum logic [1:0] {
      DPT_IDLE,
      DPT_SEND,
      DPT_WAIT
   } dpt_state_t;
endpackage

// [verilog/dpt_host_ctrl.sv]
// host controller building parameter telegram data fields and parsing replies
// assumes a framer on pclk adds start, length, address and checksum bytes
// Functional notes
// - value field is two 16-bit words, meaning set by command code
// - host puts new value to write, leaves field empty to read
// - enumerated option is selected by its number in value field
// - text telegram length varies, carried in length byte
// - text read uses command F with index high byte 4
// - text write uses command F with index high byte 5
// - data type codes 3,4,5,6,7,9,10,13,33,35; unsigned has no sign
// - values travel as whole numbers scaled by conversion factor
// - conversion index 2,1,0 give 100,10,1; negatives and 74 fractions
// - process block: control then reference out, status then frequency back
// - command E writes single word to working and nonvolatile store
// - only master starts transactions, slave replies only to queries
// - command code bits 15:12, parameter number bits 10:0
`timescale 1ns/1ps
`include "dpt_consts.svh"

module dpt_host_ctrl #(
   parameter int unsigned RESP_TIMEOUT = `DPT_TMO_US * `DPT_CLK_MHZ
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // request bytes toward the framer
   output logic      [7:0]  tx_byte,
   output logic             tx_valid,
   output logic             tx_last,
   output logic      [7:0]  tx_len,
   output logic      [7:0]  tx_addr,
   input  wire logic        tx_ready,
   // reply bytes from the framer
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_valid,
   input  wire logic        rx_last
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // picks byte k of header, n value bytes, then process words
   function automatic logic [7:0] frame_byte(input logic [3:0] k, input logic [31:0] hdr,
                                             input logic [31:0] val, input logic [2:0] n,
                                             input logic [31:0] process_word_block);
      logic [3:0] j;
      j = 4'h0;
      if (k < `DPT_HDR_BYTES) begin
         j = k;
         frame_byte = hdr[8'(31 - 8 * j) -: 8];
      end else if (k < `DPT_HDR_BYTES + {1'b0, n}) begin
         j = k - `DPT_HDR_BYTES;
         frame_byte = val[8'(31 - 8 * j) -: 8];   // high word first
      end else begin
         j = k - `DPT_HDR_BYTES - {1'b0, n};
         frame_byte = process_word_block[8'(31 - 8 * j) -: 8];   // control word then reference
      end
   endfunction

   // scales a transferred integer by a whole conversion factor
   function automatic logic [31:0] conv_scale(input logic [31:0] v, input logic [7:0] ci);
      if (ci == `DPT_CONV_X100)
         conv_scale = 32'(v * 32'h0000_0064);
      else if (ci == `DPT_CONV_X10)
         conv_scale = 32'(v * 32'h0000_000a);
      else
         conv_scale = v;                          // fractional factors left to software
   endfunction

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   dpt_pkg::dpt_state_t state_q;
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q;
   logic        bcast_q;
   logic [2:0]  nreq_q;
   logic [15:0] pid_q, index_q;
   logic [31:0] value_q, proc_q;
   logic [7:0]  addr_q, dtype_q, conv_q;
   logic        done_q, tmo_q, fault_q, cfgerr_q;
   logic [31:0] rval_q, rproc_q, scaled_q;
   logic [15:0] rpid_q;
   logic [31:0] sn_hdr_q, sn_val_q, sn_pcd_q;
   logic [2:0]  n_q;
   logic [3:0]  tx_idx_q, rx_cnt_q;
   logic [7:0]  tx_byte_q, tx_len_q, tx_addr_q;
   logic        tx_valid_q, tx_last_q;
   logic [31:0] wait_q;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   // answer in the second access cycle; pready drops right after
   wire        acc_w    = psel && penable && !pready_q;
   wire        wr_w     = psel && penable && pready_q && pwrite;
   wire        hit_ctrl = (paddr == `DPT_OFF_CTRL);
   wire        hit_stat = (paddr == `DPT_OFF_STATUS);
   wire        mapped_w = (paddr[1:0] == 2'b00) && (paddr <= `DPT_OFF_SCALED);
   wire        idle_w   = (state_q == dpt_pkg::DPT_IDLE);
   wire [3:0]  cmd_w    = pid_q[`DPT_CMD_HI:`DPT_CMD_LO];
   wire [7:0]  ihi_w    = index_q[15:8];
   wire [7:0]  st_w     = {3'h0, cfgerr_q, fault_q, tmo_q, done_q, !idle_w};
   wire [7:0]  cexp_w   = (conv_q == `DPT_CONV_SPEC) ? 8'hff : conv_q;         // index 74 means 0.1
   wire [31:0] rd_mux_w =
      (paddr == `DPT_OFF_CTRL)   ? {27'h0, nreq_q, bcast_q, 1'b0} :
      (paddr == `DPT_OFF_PID)    ? {16'h0, pid_q} :
      (paddr == `DPT_OFF_INDEX)  ? {16'h0, index_q} :
      (paddr == `DPT_OFF_VALUE)  ? value_q :
      (paddr == `DPT_OFF_PROC)   ? proc_q :
      (paddr == `DPT_OFF_ADDR)   ? {24'h0, addr_q} :
      (paddr == `DPT_OFF_DTYPE)  ? {16'h0, conv_q, dtype_q} :
      (paddr == `DPT_OFF_STATUS) ? {16'h0, cexp_w, st_w} :
      (paddr == `DPT_OFF_RVAL)   ? rval_q :
      (paddr == `DPT_OFF_RPROC)  ? rproc_q :
      (paddr == `DPT_OFF_RPID)   ? {16'h0, rpid_q} :
      (paddr == `DPT_OFF_SCALED) ? scaled_q : 32'h0000_0000;

   // ------------------------------------------------------------
   // request checks and frame set-up
   // ------------------------------------------------------------
   wire txt_w     = (cmd_w == `DPT_CMD_TEXT);
   wire txt_wr_w  = txt_w && (ihi_w == `DPT_IDX_TXT_WR);
   wire bad_txt_w = txt_w && ((dtype_q != `DPT_DT_TEXT) ||
                    ((ihi_w != `DPT_IDX_TXT_RD) && (ihi_w != `DPT_IDX_TXT_WR)));
   // a go write carries its own broadcast flag and char count; the stored copies lag by one cycle
   wire        bc_w      = pwdata[`DPT_CTRL_BCAST];
   wire [2:0]  nc_w      = pwdata[`DPT_CTRL_NHI:`DPT_CTRL_NLO];
   wire bad_adr_w = !bc_w && ((addr_q == `DPT_ADDR_BCAST) || (addr_q > `DPT_ADDR_MAX));
   wire go_w      = wr_w && hit_ctrl && pwdata[`DPT_CTRL_GO] && idle_w;
   wire start_w   = go_w && !bad_txt_w && !bad_adr_w;
   wire reject_w  = go_w && (bad_txt_w || bad_adr_w);
   // text writes carry n chars, text reads none, others the full value field
   wire [2:0]  n_w   = txt_wr_w ? nc_w : (txt_w ? 3'h0 : `DPT_VAL_BYTES);
   wire        rd_w  = (cmd_w == `DPT_CMD_RD) || (cmd_w == `DPT_CMD_NONE);
   wire        one_w = (cmd_w == `DPT_CMD_WR_W) || (cmd_w == `DPT_CMD_WR_EE_W);
   // single word writes: signed 16 extends, unsigned types carry no sign
   wire [15:0] ext_w = (dtype_q == `DPT_DT_I16) ? {16{value_q[15]}} : 16'h0000;
   wire [15:0] low_w = (dtype_q == `DPT_DT_U8) ? {8'h00, value_q[7:0]} : value_q[15:0];
   wire [31:0] val_w = rd_w ? 32'h0000_0000 :
                       (one_w ? {ext_w, low_w} : value_q);
   // only the low index byte is an array index outside text transfers
   wire [15:0] ind_w = txt_w ? index_q : {8'h00, index_q[7:0]};
   wire [15:0] pke_w = {cmd_w, 1'b0, pid_q[`DPT_PNU_HI:0]};
   wire [3:0]  nb_w  = `DPT_HDR_BYTES + `DPT_HDR_BYTES + {1'b0, n_q};
   wire        tx_go = tx_valid_q && tx_ready;
   wire        tx_end_w = tx_go && (tx_idx_q == nb_w - 4'h1);
   wire        rx_w   = rx_valid && (state_q == dpt_pkg::DPT_WAIT);
   wire        rx_end_w = rx_w && rx_last;
   wire        tmo_w  = (state_q == dpt_pkg::DPT_WAIT) && !rx_w && (wait_q == RESP_TIMEOUT - 1);
   wire [15:0] rpid_w = (rx_cnt_q == 4'h1) ? {rpid_q[15:8], rx_byte} : rpid_q;
   wire        clr_w  = wr_w && hit_stat;

   // ------------------------------------------------------------
   // apb answer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= acc_w;
         pslverr_q <= acc_w && !mapped_w;
         if (acc_w) begin
            prdata_q <= rd_mux_w;
         end
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {bcast_q, nreq_q} <= 4'h0;
         {pid_q, index_q}  <= 32'h0000_0000;
         {value_q, proc_q} <= 64'h0;
         {addr_q, dtype_q, conv_q} <= 24'h00_0000;
      end else if (wr_w) begin
         if (hit_ctrl) {nreq_q, bcast_q} <= pwdata[`DPT_CTRL_NHI:`DPT_CTRL_BCAST];
         if (paddr == `DPT_OFF_PID) pid_q <= pwdata[15:0];
         if (paddr == `DPT_OFF_INDEX) index_q <= pwdata[15:0];
         if (paddr == `DPT_OFF_VALUE) value_q <= pwdata;
         if (paddr == `DPT_OFF_PROC) proc_q <= pwdata;
         if (paddr == `DPT_OFF_ADDR) addr_q <= pwdata[7:0];
         if (paddr == `DPT_OFF_DTYPE) {conv_q, dtype_q} <= pwdata[15:0];
      end
   end

   // sticky flags: a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {done_q, tmo_q, fault_q, cfgerr_q} <= 4'h0;
      end else begin
         done_q   <= (done_q && !(clr_w && pwdata[`DPT_ST_DONE])) || rx_end_w || tmo_w ||
                     (tx_end_w && bcast_q);
         tmo_q    <= (tmo_q && !(clr_w && pwdata[`DPT_ST_TMO])) || tmo_w;
         fault_q  <= (fault_q && !(clr_w && pwdata[`DPT_ST_FAULT])) ||
                     (rx_end_w && rpid_w[`DPT_CMD_HI:`DPT_CMD_LO] == `DPT_RSP_FAULT);
         cfgerr_q <= (cfgerr_q && !(clr_w && pwdata[`DPT_ST_CFGERR])) || reject_w;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   // one query at a time; broadcasts expect no reply
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= dpt_pkg::DPT_IDLE;
      end else begin
         unique case (state_q)
            dpt_pkg::DPT_IDLE: if (start_w) state_q <= dpt_pkg::DPT_SEND;
            dpt_pkg::DPT_SEND: if (tx_end_w) state_q <= bcast_q ? dpt_pkg::DPT_IDLE
                                                                : dpt_pkg::DPT_WAIT;
            dpt_pkg::DPT_WAIT: if (rx_end_w || tmo_w) state_q <= dpt_pkg::DPT_IDLE;
            default: state_q <= dpt_pkg::DPT_IDLE;
         endcase
      end
   end

   // snapshot so software may reprogram while a frame is out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {sn_hdr_q, sn_val_q, sn_pcd_q} <= 96'h0;
         n_q <= 3'h0;
      end else if (start_w) begin
         sn_hdr_q <= {pke_w, ind_w};
         sn_val_q <= val_w;
         sn_pcd_q <= proc_q;                    // control word in the high half
         n_q      <= n_w;
      end
   end

   // byte stream toward the framer, valid held until taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {tx_valid_q, tx_last_q} <= 2'b00;
         {tx_byte_q, tx_len_q, tx_addr_q} <= 24'h00_0000;
         tx_idx_q <= 4'h0;
      end else if (start_w) begin
         tx_valid_q <= 1'b1;
         tx_idx_q   <= 4'h0;
         tx_byte_q  <= pke_w[15:8];
         tx_last_q  <= 1'b0;
         tx_len_q   <= `DPT_LEN_FIXED + {5'h00, n_w};
         tx_addr_q  <= bc_w ? `DPT_ADDR_BCAST : addr_q;
      end else if (tx_end_w) begin
         {tx_valid_q, tx_last_q} <= 2'b00;
      end else if (tx_go) begin
         tx_idx_q  <= tx_idx_q + 4'h1;
         tx_byte_q <= frame_byte(tx_idx_q + 4'h1, sn_hdr_q, sn_val_q, n_q, sn_pcd_q);
         tx_last_q <= (tx_idx_q + 4'h2 == nb_w);
      end
   end

   // reply capture: header, value field, last four bytes are process words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {rval_q, rproc_q, scaled_q} <= 96'h0;
         rpid_q   <= 16'h0000;
         rx_cnt_q <= 4'h0;
         wait_q   <= 32'h0000_0000;
      end else if (start_w) begin
         rx_cnt_q <= 4'h0;
         wait_q   <= 32'h0000_0000;
      end else if (rx_w) begin
         rx_cnt_q <= (rx_cnt_q == 4'hf) ? rx_cnt_q : rx_cnt_q + 4'h1;
         rpid_q   <= (rx_cnt_q == 4'h0) ? {rx_byte, rpid_q[7:0]} : rpid_w;
         if (rx_cnt_q >= `DPT_HDR_BYTES && rx_cnt_q < 4'h8)
            rval_q <= {rval_q[23:0], rx_byte};
         rproc_q  <= {rproc_q[23:0], rx_byte};                                      // status then frequency
         if (rx_last)
            scaled_q <= conv_scale(rval_q, conv_q);
      end else if (state_q == dpt_pkg::DPT_WAIT) begin
         wait_q <= wait_q + 32'h0000_0001;
      end
   end

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign tx_byte  = tx_byte_q;
   assign tx_valid = tx_valid_q;
   assign tx_last  = tx_last_q;
   assign tx_len   = tx_len_q;
   assign tx_addr  = tx_addr_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   text_len_a: assert property ($rose(tx_valid_q) |-> tx_len_q == `DPT_LEN_FIXED + {5'h00, n_q})
      else $error("length byte does not match value byte count");
   high_first_a: assert property (
      tx_valid_q && tx_idx_q == 4'h4 && n_q == 3'h4 |-> tx_byte_q == sn_val_q[31:24])
      else $error("value field high byte not sent first");
   bcast_nowait_a: assert property (tx_end_w && bcast_q |=> state_q == dpt_pkg::DPT_IDLE && done_q)
      else $error("broadcast waited for a reply");
   text_type_a: assert property (
      go_w && txt_w && dtype_q != `DPT_DT_TEXT |=> idle_w && cfgerr_q && !tx_valid_q)
      else $error("text request on non text type was sent");
   one_txn_a: assert property ($rose(tx_valid_q) |-> $past(state_q) == dpt_pkg::DPT_IDLE)
      else $error("frame started while a query was open");
   fault_flag_a: assert property (
      rx_end_w && rpid_w[`DPT_CMD_HI:`DPT_CMD_LO] == `DPT_RSP_FAULT |=> fault_q && idle_w)
      else $error("fault reply not flagged");
   idx_low_a: assert property (
      tx_valid_q && tx_idx_q == 4'h2 && sn_hdr_q[31:28] != `DPT_CMD_TEXT |-> tx_byte_q == 8'h00)
      else $error("index high byte sent outside text transfer");
   timeout_a: assert property (tmo_w |=> tmo_q && idle_w ##1 !tx_valid_q)
      else $error("reply timeout not taken");
   read_empty_a: assert property (
      state_q == dpt_pkg::DPT_SEND && sn_hdr_q[31:28] == `DPT_CMD_RD |-> sn_val_q == 32'h0)
      else $error("read request carried a value");
   rval_cap_a: assert property (rx_w && rx_cnt_q == 4'h7 |=> rval_q[7:0] == $past(rx_byte))
      else $error("reply value byte not captured");
   apb_ans_a: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
      else $error("apb answer timing wrong");

   bcast_cv: cover property (tx_end_w && bcast_q);
   tmo_cv: cover property (tmo_w);
   text_cv: cover property (start_w && txt_wr_w ##[1:40] rx_end_w);
   fault_cv: cover property (rx_end_w && rpid_w[`DPT_CMD_HI:`DPT_CMD_LO] == `DPT_RSP_FAULT);

endmodule

// [dv/dpt_dev_model.sv]
// behavioural drive at the far side of the framer: takes request frames, answers with replies
// assumes byte handshakes on pclk and a 12-byte reply layout as the controller parses it
`timescale 1ns/1ps

module dpt_dev_model #(
   parameter logic [15:0] STATUS_W = 16'h0607,  // arbitrary drive status word
   parameter logic [15:0] FREQ_W   = 16'h1f40   // arbitrary present output frequency
) (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // request side
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_valid,
   input  wire logic       tx_last,
   input  wire logic [7:0] tx_addr,
   output logic            tx_ready,
   // reply side
   output logic      [7:0] rx_byte,
   output logic            rx_valid,
   output logic            rx_last,
   // scenario control: stay silent so the controller must time out
   input  wire logic       mute
);
   logic [7:0]  q[$];
   logic [7:0]  frm[$];
   logic [31:0] mem[0:2047];
   logic [7:0]  b[0:11];
   logic [31:0] rv;
   logic [3:0]  code;

   // answer only after a whole query; a busy framer is mimicked by random stalls
   task automatic reply();
      frm = q;
      q.delete();
      if (tx_addr == 8'h00 || mute) return;
      code = frm[0][7:4];
      rv   = {frm[4], frm[5], frm[6], frm[7]};
      if ({frm[0][2:0], frm[1]} >= 11'd1000) begin
         code = 4'h7;
         rv   = 32'h0;  // unknown parameter number
      end else if (code == 4'h2 || code == 4'he) begin
         mem[{frm[0][2:0], frm[1]}] = rv;
         code = 4'h1;
      end else begin
         rv = mem[{frm[0][2:0], frm[1]}];
      end
      b = '{{code, frm[0][3:0]}, frm[1], frm[2], frm[3], rv[31:24], rv[23:16], rv[15:8], rv[7:0],
            STATUS_W[15:8], STATUS_W[7:0], FREQ_W[15:8], FREQ_W[7:0]};
      repeat (3) @(posedge pclk);
      for (int k = 0; k < 12; k++) begin
         rx_byte  <= b[k];
         rx_valid <= 1'b1;
         rx_last  <= (k == 11);
         @(posedge pclk);
      end
      rx_valid <= 1'b0;
      rx_last  <= 1'b0;
      rx_byte  <= ~b[11];  // released line shows no stale value
   endtask

   // byte intake loop
   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_last  = 1'b0;
      rx_byte  = 8'h00;
      foreach (mem[i]) mem[i] = 32'h0;
      forever begin
         @(posedge pclk);
         if (presetn && tx_valid && tx_ready) begin
            q.push_back(tx_byte);
            if (tx_last) reply();
         end
         tx_ready <= presetn && ($urandom_range(1, 0) == 1);
      end
   end
endmodule

// [dv/test_dpt_host_ctrl.sv]
// self-checking bench for the telegram host controller with a behavioural drive model
// assumes the controller's registers at the offsets of dpt_consts.svh and a short response timeout
`timescale 1ns/1ps
`include "dpt_consts.svh"

module test_dpt_host_ctrl;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mute = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r, st, rv, rp, rpid, sc;
   logic        pready, pslverr, e, tx_valid, tx_last, tx_ready, rx_valid, rx_last;
   logic [7:0]  tx_byte, tx_len, tx_addr, rx_byte;
   logic [10:0] pn;
   logic [15:0] v;
   int          n_mismatch = 0, check_count = 0;

   always #25 pclk = ~pclk;

   dpt_host_ctrl #(.RESP_TIMEOUT(50)) i_dpt_host_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last), .tx_len(tx_len),
      .tx_addr(tx_addr), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_last(rx_last));
   dpt_dev_model i_dpt_dev_model (.pclk(pclk), .presetn(presetn), .tx_byte(tx_byte), .tx_valid(tx_valid),
      .tx_last(tx_last), .tx_addr(tx_addr), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .rx_last(rx_last), .mute(mute));

   // ----------------------------------------
   // reporting
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      check_count++;
      if (seen !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   // ----------------------------------------
   // apb master: request held until pready is sampled high
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin n_mismatch++; close_out(); end
      r = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask

   // one complete telegram through the registers, then fetch every result
   task automatic op(input logic [15:0] pid, idx, input logic [31:0] val, input logic [7:0] adr,
                     input logic [15:0] dt, input logic [4:0] ctl);
      int k;
      apb(1, `DPT_OFF_STATUS, 32'h1f); apb(1, `DPT_OFF_PID, {16'h0, pid}); apb(1, `DPT_OFF_INDEX, {16'h0, idx});
      apb(1, `DPT_OFF_VALUE, val); apb(1, `DPT_OFF_PROC, 32'h047f_1000); apb(1, `DPT_OFF_ADDR, {24'h0, adr});
      apb(1, `DPT_OFF_DTYPE, {16'h0, dt}); apb(1, `DPT_OFF_CTRL, {27'h0, ctl});
      for (k = 0; k < 400; k++) begin
         apb(0, `DPT_OFF_STATUS, 32'h0);
         if (r[1] === 1'b1 || r[4] === 1'b1) break;
      end
      if (k == 400) begin n_mismatch++; close_out(); end
      st = r;
      apb(0, `DPT_OFF_RVAL, 0); rv = r; apb(0, `DPT_OFF_RPROC, 0); rp = r;
      apb(0, `DPT_OFF_RPID, 0); rpid = r; apb(0, `DPT_OFF_SCALED, 0); sc = r;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'hf039));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, 8'h30, 0); chk("unmapped_err", {31'h0, e}, 1); chk("unmapped_data", r, 0);
      pn = 11'($urandom_range(999, 1)); v = 16'($urandom);
      op({4'he, 1'b0, pn}, 16'h0, {16'h0, v}, 8'd5, 16'h0206, 5'h01);
      chk("ee_write_status", st[4:0], 5'h02);
      chk("ee_write_len", tx_len, 14);
      chk("ee_write_addr", {24'h0, tx_addr}, 5);
      chk("ee_write_lo", {i_dpt_dev_model.frm[6], i_dpt_dev_model.frm[7]}, v);
      op({4'h1, 1'b0, pn}, 16'h0, 32'h0, 8'd5, 16'h0206, 5'h01);
      chk("read_value", rv, {16'h0, v});
      chk("read_field_empty", {i_dpt_dev_model.frm[4], i_dpt_dev_model.frm[5], i_dpt_dev_model.frm[6],
          i_dpt_dev_model.frm[7]}, 0);
      chk("read_scaled", sc, v * 100);
      chk("read_proc", rp, 32'h0607_1f40);
      chk("read_code", rpid[15:12], 1);
      op({4'h2, 1'b0, pn}, 16'h0, 32'h4, 8'd9, 16'h0105, 5'h01);
      op({4'h1, 1'b0, pn}, 16'h0, 32'h0, 8'd9, 16'h0105, 5'h01);
      chk("enum_value", rv, 4);
      chk("enum_scaled", sc, 40);
      op({4'h1, 1'b0, 11'd1500}, 16'h0003, 32'h0, 8'd5, 16'h0006, 5'h01);
      chk("fault_flag", st[3], 1);
      chk("fault_code", rpid[15:12], 7);
      chk("fault_report", rv[15:0], 0);
      op({4'h2, 1'b0, pn}, 16'h0, 32'h7, 8'd0, 16'h0006, 5'h03);
      chk("bcast_status", st[4:0], 5'h02);
      chk("bcast_addr", {24'h0, tx_addr}, 0);
      mute <= 1'b1;
      op({4'h1, 1'b0, pn}, 16'h0, 32'h0, 8'd7, 16'h0006, 5'h01);
      chk("silent_timeout", st[2], 1);
      mute <= 1'b0;
      op({4'hf, 1'b0, pn}, 16'h0400, 32'h0, 8'd5, 16'h0006, 5'h01);
      chk("text_type_err", st[4], 1);
      op({4'hf, 1'b0, pn}, 16'h0300, 32'h0, 8'd5, 16'h0009, 5'h01);
      chk("text_index_err", st[4], 1);
      op({4'h1, 1'b0, pn}, 16'h0, 32'h0, 8'd248, 16'h0006, 5'h01);
      chk("addr_range_err", st[4], 1);
      op({4'hf, 1'b0, pn}, 16'h0400, 32'h0, 8'd247, 16'h0009, 5'h01);
      chk("text_read_len", tx_len, 10);
      op({4'hf, 1'b0, pn}, 16'h0500, 32'h4142_0000, 8'd1, 16'h0009, 5'h09);
      chk("text_write_len", tx_len, 12);
      close_out();
   end
endmodule
